//--- rtl/acc_map.vh
`ifndef ACC_MAP_VH
`define ACC_MAP_VH
// Register addresses on the special-function bus.
`define ACC_ADDR_CTRL      8'hf3
`define ACC_ADDR_RES_HI    8'hf5
`define ACC_ADDR_RES_LO    8'hf4
`define ACC_ADDR_IRQ_STAT  8'hf8
`define ACC_ADDR_IRQ_MASK  8'hf9
// Control register field positions.
`define ACC_BIT_QUIET      7
`define ACC_BIT_PSEUDO_IDLE_BIT     6
`define ACC_BIT_ENABLE     5
`define ACC_BIT_DONE       4
`define ACC_BIT_START      3
`define ACC_CHAN_MSB       2
`define ACC_CHAN_LSB       0
// Interrupt enable bit position within the core's interrupt enable register.
`define ACC_BIT_IRQ_EN     6
// Reset values.
`define ACC_CTRL_RESET     8'h00
`define ACC_MASK_RESET     8'h00
// Highest channel code wired to an analog input.
`define ACC_CHAN_LAST      3'h5
`endif

//--- rtl/acc_ctrl.v
// Operation
// - Writing one to bit 3 starts conversion; hardware clears it when finished.
// - Bit 7 requests quiet mode, only converter active during conversion.
// - Bit 6 idles the processor during conversion; bits 6,7 self-clear at end.
// - Bit 5 powers the converter; clear means standby.
// - Hardware sets done flag bit 4 when result is ready; interrupt source.
// - Done flag only cleared by software writing zero; re-arms the interrupt.
// - Bits 2 to 0 select the analog channel for the next conversion.
// - After reset the control register reads zero: standby, idle, channel zero.
// - Writes to the start bit are ignored while a conversion runs.
// - Done flag rises only once the 10-bit result is held in result registers.
// - Interrupt request when done flag and converter interrupt enable are both set.
// - Channel codes zero to five pick inputs zero to five; six, seven unassigned.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "acc_map.vh"

module acc_ctrl #(
  parameter RES_W = 10
) (
  input  wire             sys_clk_i,
  input  wire             srst_i,
  input  wire [7:0]       addr_i,
  input  wire [7:0]       wdata_i,
  input  wire             wr_i,
  input  wire             rd_i,
  output wire [7:0]       rdata_o,
  input  wire             irq_en_i,
  input  wire             conv_done_i,
  input  wire [RES_W-1:0] conv_result_i,
  output wire             conv_start_o,
  output wire [2:0]       chan_sel_o,
  output wire             chan_valid_o,
  output wire             conv_enable_o,
  output wire             cpu_idle_o,
  output wire             quiet_mode_o,
  output wire             irq_req_o,
  output wire             irq_o
);

  // Control register bits, then result, read data, start, interrupt, status and mask state.
  reg             quiet_ff;
  reg             pseudo_idle_bit_ff;
  reg             enable_ff;
  reg             done_ff;
  reg             busy_ff;
  reg [2:0]       chan_ff;
  reg [RES_W-1:0] result_ff;
  reg [7:0]       rdata_ff;
  reg             start_ff;
  reg             irq_req_ff;
  reg             irq_ff;
  reg [1:0]       stat_ff;
  reg [1:0]       mask_ff;
  // Derived outputs are kept in flops so that no output glitches on a decode.
  reg             chan_valid_ff;
  reg             cpu_idle_ff;
  reg             quiet_mode_ff;

  reg             nxt_quiet;
  reg             nxt_pseudo_idle_bit;
  reg             nxt_enable;
  reg             nxt_done;
  reg             nxt_busy;
  reg [2:0]       nxt_chan;
  reg [RES_W-1:0] nxt_result;
  reg [7:0]       nxt_rdata;
  reg [1:0]       nxt_stat;

  wire wr_ctrl = wr_i && (addr_i == `ACC_ADDR_CTRL);
  wire rd_stat = rd_i && (addr_i == `ACC_ADDR_IRQ_STAT);
  // A conversion ends only on a completion from the analog core while busy.
  wire finish  = busy_ff && conv_done_i;
  wire start_req = wr_ctrl && !busy_ff && wdata_i[`ACC_BIT_START];

  // Packs the control register image for readback.
  function [7:0] ctrl_image;
    input q, p, e, d, b;
    input [2:0] c;
    begin
      ctrl_image = {q, p, e, d, b, c};
    end
  endfunction

  // Control register next-state logic.
  always @* begin
    nxt_quiet  = quiet_ff;
    nxt_pseudo_idle_bit = pseudo_idle_bit_ff;
    nxt_enable = enable_ff;
    nxt_done   = done_ff;
    nxt_busy   = busy_ff;
    nxt_chan   = chan_ff;
    nxt_result = result_ff;
    if (wr_ctrl) begin
      nxt_quiet  = wdata_i[`ACC_BIT_QUIET];
      nxt_pseudo_idle_bit = wdata_i[`ACC_BIT_PSEUDO_IDLE_BIT];
      nxt_enable = wdata_i[`ACC_BIT_ENABLE];
      nxt_chan   = wdata_i[`ACC_CHAN_MSB:`ACC_CHAN_LSB];
      // Software may only clear the done flag, never set it.
      if (!wdata_i[`ACC_BIT_DONE]) begin
        nxt_done = 1'b0;
      end
      if (start_req) begin
        nxt_busy = 1'b1;
      end
    end
    // Completion wins over a same-cycle software clear of the done flag.
    if (finish) begin
      nxt_result = conv_result_i;
      nxt_done   = 1'b1;
      nxt_busy   = 1'b0;
      nxt_quiet  = 1'b0;
      nxt_pseudo_idle_bit = 1'b0;
    end
  end

  // Status sticky bits: bit 0 completion, bit 1 start accepted; read clears, set wins.
  always @* begin
    nxt_stat = stat_ff;
    if (rd_stat) begin
      nxt_stat = 2'h0;
    end
    if (finish) begin
      nxt_stat[0] = 1'b1;
    end
    if (start_req) begin
      nxt_stat[1] = 1'b1;
    end
  end

  // Read data mux; unmapped addresses read zero.
  always @* begin
    nxt_rdata = 8'h00;
    if (rd_i) begin
      case (addr_i)
        `ACC_ADDR_CTRL:     nxt_rdata = ctrl_image(quiet_ff, pseudo_idle_bit_ff, enable_ff, done_ff, busy_ff, chan_ff);
        `ACC_ADDR_RES_HI:   nxt_rdata = result_ff[RES_W-1:RES_W-8];
        `ACC_ADDR_RES_LO:   nxt_rdata = {6'h00, result_ff[1:0]};
        `ACC_ADDR_IRQ_STAT: nxt_rdata = {6'h00, stat_ff};
        `ACC_ADDR_IRQ_MASK: nxt_rdata = {6'h00, mask_ff};
        default:            nxt_rdata = 8'h00;
      endcase
    end
  end

  // All state is synchronous; quiet bit resets to zero as a safe choice for the undefined value.
  always @(posedge sys_clk_i) begin
    if (srst_i) begin
      {quiet_ff, pseudo_idle_bit_ff, enable_ff, done_ff, busy_ff, chan_ff} <= `ACC_CTRL_RESET;
      result_ff  <= {RES_W{1'b0}};
      rdata_ff   <= 8'h00;
      start_ff   <= 1'b0;
      irq_req_ff <= 1'b0;
      irq_ff     <= 1'b0;
      stat_ff    <= 2'h0;
      mask_ff    <= 2'h0;
      // Channel zero is selected after reset, and it is a wired input.
      chan_valid_ff <= 1'b1;
      cpu_idle_ff   <= 1'b0;
      quiet_mode_ff <= 1'b0;
    end else begin
      // Registered from next-state values, so each output matches its register bits in the same cycle.
      chan_valid_ff <= (nxt_chan <= `ACC_CHAN_LAST);
      cpu_idle_ff   <= nxt_pseudo_idle_bit && nxt_busy;
      quiet_mode_ff <= nxt_quiet && nxt_busy;
      quiet_ff   <= nxt_quiet;
      pseudo_idle_bit_ff  <= nxt_pseudo_idle_bit;
      enable_ff  <= nxt_enable;
      done_ff    <= nxt_done;
      busy_ff    <= nxt_busy;
      chan_ff    <= nxt_chan;
      result_ff  <= nxt_result;
      rdata_ff   <= nxt_rdata;
      start_ff   <= start_req;
      // Interrupt request follows the done flag gated by the core's enable.
      irq_req_ff <= nxt_done && irq_en_i;
      stat_ff    <= nxt_stat;
      if (wr_i && addr_i == `ACC_ADDR_IRQ_MASK) begin
        mask_ff <= wdata_i[1:0];
      end
      irq_ff     <= |(nxt_stat & mask_ff);
    end
  end

  assign rdata_o       = rdata_ff;
  assign conv_start_o  = start_ff;
  assign chan_sel_o    = chan_ff;
  // Codes six and seven have no input behind them.
  assign chan_valid_o  = chan_valid_ff;
  // Power gating is only as good as the enable; a start is still accepted in standby.
  assign conv_enable_o = enable_ff;
  assign cpu_idle_o    = cpu_idle_ff;
  assign quiet_mode_o  = quiet_mode_ff;
  assign irq_req_o     = irq_req_ff;
  assign irq_o         = irq_ff;

endmodule // acc_ctrl

//--- verification/acc_ctrl_chk.sv
`timescale 1ns/1ps
module acc_ctrl_chk (
  input wire       sys_clk_i, srst_i, wr_i, irq_en_i, conv_done_i, conv_start_o,
  input wire       chan_valid_o, conv_enable_o, cpu_idle_o, quiet_mode_o, irq_req_o,
  input wire [7:0] addr_i, wdata_i,
  input wire [2:0] chan_sel_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);
  // A control write, and a completion seen while a hold bit keeps the core quiet.
  sequence s_wr; wr_i && addr_i == 8'hf3; endsequence
  sequence s_end; conv_done_i && (cpu_idle_o || quiet_mode_o); endsequence
  // A retrigger in mid-conversion would corrupt the sample, so the pulse is single.
  start_pulse_a: assert property (conv_start_o |-> $past(wr_i && wdata_i[3]) ##1 !conv_start_o)
    else $error("bad start pulse");
  busy_write_a: assert property (cpu_idle_o && wr_i && !conv_done_i |=> !conv_start_o)
    else $error("start taken while busy");
  hold_set_a: assert property (conv_start_o |-> {quiet_mode_o, cpu_idle_o} == $past(wdata_i[7:6]))
    else $error("hold bits wrong at start");
  hold_end_a: assert property (s_end |=> !cpu_idle_o && !quiet_mode_o)
    else $error("hold bits not cleared");
  enable_wr_a: assert property (s_wr |=> conv_enable_o == $past(wdata_i[5]))
    else $error("enable not written");
  chan_wr_a: assert property (s_wr |=> chan_sel_o == $past(wdata_i[2:0]))
    else $error("channel not written");
  chan_valid_a: assert property (chan_valid_o == (chan_sel_o < 3'h6))
    else $error("channel valid wrong");
  irq_req_a: assert property (s_end ##0 irq_en_i ##1 irq_en_i |=> irq_req_o)
    else $error("no interrupt request");
endmodule // acc_ctrl_chk

bind acc_ctrl acc_ctrl_chk i_acc_ctrl_chk (.*);

//--- verification/acc_ctrl_tb.sv
`timescale 1ns/1ps
module acc_ctrl_tb;
  reg        sys_clk_i = 0, srst_i = 1, wr_i = 0, rd_i = 0, irq_en_i = 0, conv_done_i = 0;
  reg  [7:0] addr_i = 0, wdata_i = 0;
  reg  [9:0] conv_result_i = 0;
  wire [7:0] rdata_o;
  wire [2:0] chan_sel_o;
  wire       conv_start_o, chan_valid_o, conv_enable_o, cpu_idle_o, quiet_mode_o, irq_req_o, irq_o;
  integer    errors = 0, n_tests = 0, cyc = 0, c;
  acc_ctrl i_acc_ctrl (.*);
  // Clock at 10 MHz.
  initial begin
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // A hang would never reach the verdict, so the run is capped.
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      errors = errors + 1;
      end_sim;
    end
  end
  task chk(input [9:0] s, input [9:0] e);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        errors = errors + 1;
        $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
    end
  endtask
  // Bus cycles: one strobe cycle each, read data sampled in the cycle after.
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge sys_clk_i);
      {wr_i, addr_i, wdata_i} <= {1'b1, a, d};
      @(posedge sys_clk_i);
      wr_i <= 0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge sys_clk_i);
      {rd_i, addr_i} <= {1'b1, a};
      @(posedge sys_clk_i);
      rd_i <= 0;
      #1 chk(rdata_o, e);
    end
  endtask
  // Completion pulse from the analog core, then time for the flags to settle.
  task fin(input [9:0] r);
    begin
      @(posedge sys_clk_i);
      {conv_done_i, conv_result_i} <= {1'b1, r};
      @(posedge sys_clk_i);
      conv_done_i <= 0;
      repeat (2) @(posedge sys_clk_i);
    end
  endtask
  task t_conv;
    begin
      irq_en_i <= 1;
      wr(8'hf9, 8'h01);
      wr(8'hf3, 8'he9);
      #1 chk({conv_start_o, cpu_idle_o, quiet_mode_o, conv_enable_o}, 4'hf);
      wr(8'hf3, 8'hed);
      #1 chk(conv_start_o, 1'b0);
      rd(8'hf3, 8'hed);
      fin(10'h2c5);
      #1 chk({irq_req_o, irq_o, cpu_idle_o}, 3'h6);
      rd(8'hf3, 8'h35);
      rd(8'hf5, 8'hb1);
      rd(8'hf4, 8'h01);
      rd(8'hf8, 8'h03);
      rd(8'hf8, 8'h00);
      wr(8'hf3, 8'h35);
      rd(8'hf3, 8'h35);
      wr(8'hf3, 8'h25);
      rd(8'hf3, 8'h25);
      chk({irq_req_o, irq_o}, 2'h0);
      $display("conversion test ended");
    end
  endtask
  // Masked status and a disabled request path must both stay quiet.
  task t_mask;
    begin
      {irq_en_i, addr_i} <= 0;
      wr(8'hf9, 8'h00);
      wr(8'hf3, 8'h28);
      fin(10'h3ff);
      #1 chk({irq_req_o, irq_o}, 2'h0);
      irq_en_i <= 1;
      rd(8'hf8, 8'h03);
      chk({irq_req_o, irq_o}, 2'h2);
      $display("mask test ended");
    end
  endtask
  task t_chan;
    begin
      for (c = 0; c < 8; c = c + 1) begin
        wr(8'hf3, {5'h04, c[2:0]});
        #1 chk({chan_valid_o, chan_sel_o}, {c < 6, c[2:0]});
      end
      rd(8'h10, 8'h00);
      $display("channel test ended");
    end
  endtask
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (10) @(posedge sys_clk_i);
    srst_i <= 0;
    rd(8'hf3, 8'h00);
    t_conv;
    t_mask;
    t_chan;
    end_sim;
  end
endmodule // acc_ctrl_tb
